/* adcf_map.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  adaptive dc feed controller.
  Assumes inclusion by its bare name before the package and modules.
*/
`ifndef ADCF_MAP_SVH
`define ADCF_MAP_SVH

// Clock and converter rates
`define ADCF_CLK_HZ 10000000
`define ADCF_SLOW_HZ 800
`define ADCF_FAST_HZ 8000
`define ADCF_CAL_CYCLES 1024

// Current limit code to microamps
`define ADCF_LOOP_CURRENT_LIMIT_BASE_UA 18000
`define ADCF_LOOP_CURRENT_LIMIT_STEP_UA 875
`define ADCF_CUR_LSB_UA 400

// Register byte offsets; setting words sit at 4 * index
`define ADCF_OFS_CTRL 8'h00
`define ADCF_IDX_LOOP_CURRENT_LIMIT 4'h1
`define ADCF_IDX_VOC 4'h2
`define ADCF_IDX_VCM 4'h3
`define ADCF_IDX_VOV 4'h4
`define ADCF_IDX_LTH 4'h5
`define ADCF_IDX_HTH 4'h6
`define ADCF_IDX_BOOST 4'h7
`define ADCF_IDX_LC_OFF 4'h8
`define ADCF_IDX_LC_ON 4'h9
`define ADCF_IDX_LC_FILT 4'ha
`define ADCF_IDX_LC_DEB 4'hb
`define ADCF_IDX_GK_LO 4'hc
`define ADCF_IDX_GK_HI 4'hd
`define ADCF_IDX_GK_FILT 4'he
`define ADCF_IDX_GK_DEB 4'hf
`define ADCF_OFS_STATUS 8'h40
`define ADCF_OFS_TRACK 8'h44
`define ADCF_OFS_LOOP_V 8'h48
`define ADCF_OFS_LOOP_I 8'h4c
`define ADCF_OFS_RING_V 8'h50
`define ADCF_OFS_RING_I 8'h54

// Control word fields
`define ADCF_CTRL_FEED_MSB 2
`define ADCF_CTRL_DISC_BIT 3
`define ADCF_CTRL_CAL_BIT 4

// Reset values
`define ADCF_CFG_RST 16'h0000
`define ADCF_SAMPLE_RST 8'h00

// Feed state codes
`define ADCF_LF_OPEN 3'h0
`define ADCF_LF_FWD 3'h1
`define ADCF_LF_TIP_OPEN 3'h3
`define ADCF_LF_REV 3'h5
`define ADCF_LF_RING_OPEN 3'h7

`endif

/* adcf_pkg.sv */
/*
  Types of the adaptive dc feed controller.
  Assumes adcf_map.svh is available on the include path.
*/
package adcf_pkg;
  typedef struct packed {
    logic [7:0] vtip;
    logic [7:0] vring;
    logic [7:0] iloop;
    logic [7:0] iring;
    logic [7:0] ilong;
    logic [7:0] vbat;
  } adcf_slow_t;

  typedef struct packed {
    logic [7:0] vrng;
    logic [7:0] irng;
  } adcf_fast_t;

  typedef struct packed {
    logic [2:0] state;
    logic tip_drive_en;
    logic ring_drive_en;
    logic imp_high;
    logic const_current;
    logic [15:0] ocv;
    logic [15:0] limit_ua;
  } adcf_feed_t;

  typedef enum logic {ADCF_PRE, ADCF_POST} adcf_region_t;
  typedef enum logic {ADCF_CAL_IDLE, ADCF_CAL_RUN} adcf_cal_t;
endpackage : adcf_pkg

/* adcf_detect.sv */
/*
  Threshold detector: low-pass filter, hysteresis and debounce.
  Assumes sample_en pulses once per new converter sample.
*/
`timescale 1ns/1ps
module adcf_detect #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_en,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] low_thr,
  input wire logic [W-1:0] high_thr,
  input wire logic [3:0] filt_shift,
  input wire logic [15:0] debounce,
  output logic flag
);
  logic [W-1:0] filt_reg;
  logic [15:0] cnt_reg;
  logic flag_reg;
  wire signed [W:0] diff = $signed({1'b0, value}) - $signed({1'b0, filt_reg});
  wire signed [W:0] step = diff >>> filt_shift;
  wire [W-1:0] filt_next = filt_reg + step[W-1:0];
  // Hysteresis: rise at high, fall at low
  wire want = flag_reg ? (filt_next > low_thr) : (filt_next >= high_thr);
  wire differ = want != flag_reg;
  wire flip = differ && (cnt_reg >= debounce);

  assign flag = flag_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filt_reg <= '0;
      cnt_reg <= 16'h0000;
      flag_reg <= 1'b0;
    end
    else if (sample_en)
    begin
      filt_reg <= filt_next;
      cnt_reg <= (differ && !flip) ? cnt_reg + 16'h0001 : 16'h0000;
      if (flip)
        flag_reg <= want;
    end
  end
endmodule : adcf_detect

/* adcf_ctrl.sv */
/*
  Adaptive dc feed controller: settings registers on Avalon-MM,
  battery tracking, adaptive impedance region, ground start,
  loop closure and ground key detection, calibration, sampling.
  Assumes converter sample buses are synchronous to clk.
*/
// The address map and the Avalon-MM register port were chosen for this implementation.
//
// Behaviour
// - 5-bit current limit maps 18 mA plus 0.875 mA per code.
// - Integrated driver 640 ohm pre transition, 320 after; discrete 320.
// - Low threshold reached: go 320 ohm and add boost to voltage.
// - Hold low impedance until current limit, then constant current.
// - High threshold reached: back to prior impedance, remove boost.
// - Zero boost removes only the boost; impedance change stays.
// - Track equals setting, or battery less overhead and common mode.
// - Thresholds are signed offsets from the tracked voltage.
// - State 011 floats tip, 111 floats ring; other lead driven.
// - Ground start active lead uses the same adaptive behaviour; code always adapts on the ring lead, which is active only in 011.
// - Ground key detect with filter, thresholds, debounce; set flag.
// - Ground key moves tip-float to forward, ring-float to reverse.
// - Loop closure detect with filter, thresholds, debounce; set flag.
// - Calibration bit starts calibration and clears itself when done.
// - Reset leaves feed open, ready for calibration.
// - Samples update at 800 Hz; ringing samples at 8 kHz.
// - Report loop voltage and current; ring lead values in ground start.
// - Open is 000, forward 001, reverse 101; open by default.
`timescale 1ns/1ps
`include "adcf_map.svh"
module adcf_ctrl #(
  parameter int SLOW_DIV = `ADCF_CLK_HZ / `ADCF_SLOW_HZ,
  parameter int FAST_DIV = `ADCF_CLK_HZ / `ADCF_FAST_HZ,
  parameter int CAL_CYCLES = `ADCF_CAL_CYCLES,
  parameter int CUR_LSB_UA = `ADCF_CUR_LSB_UA
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire adcf_pkg::adcf_slow_t slow_in,
  input wire adcf_pkg::adcf_fast_t fast_in,
  output adcf_pkg::adcf_feed_t feed_out,
  output logic cal_active
);
  import adcf_pkg::*;

  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
    wmerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : wmerge

  function automatic logic [15:0] scale8(input logic [7:0] s);
    scale8 = {s, 8'h00};
  endfunction : scale8

  // Current limit code in microamps
  function automatic logic [15:0] loop_current_limit_ua(input logic [4:0] code);
    loop_current_limit_ua = 16'(`ADCF_LOOP_CURRENT_LIMIT_BASE_UA + `ADCF_LOOP_CURRENT_LIMIT_STEP_UA * code);
  endfunction : loop_current_limit_ua

  logic [15:0] cfg_reg [1:15];
  logic [2:0] feed_reg;
  logic disc_reg;
  adcf_cal_t cal_reg;
  logic [15:0] cal_cnt_reg;
  adcf_region_t region_reg;
  logic cc_reg;
  logic [15:0] track_reg;
  logic [15:0] loop_v_reg;
  logic [15:0] loop_i_reg;
  logic [7:0] vrng_reg;
  logic [7:0] irng_reg;
  adcf_slow_t slow_reg;
  logic [15:0] slow_cnt_reg;
  logic [15:0] fast_cnt_reg;
  logic slow_en_reg;
  logic fast_en_reg;
  logic eval_en_reg;
  logic gk_prev_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  adcf_feed_t feed_out_reg;

  // Bus decode
  wire wr_fire = avs_write && !wait_reg;
  wire [3:0] idx = avs_address[5:2];
  wire cfg_hit = (avs_address[7:6] == 2'b00) && (idx != 4'h0);
  wire ctrl_hit = avs_address == `ADCF_OFS_CTRL;
  wire ctrl_wr = wr_fire && ctrl_hit && avs_byteenable[0];

  // Dividers
  wire slow_wrap = slow_cnt_reg == 16'(SLOW_DIV - 1);
  wire fast_wrap = fast_cnt_reg == 16'(FAST_DIV - 1);

  // Ground start and reported values
  wire gs_tip = feed_reg == `ADCF_LF_TIP_OPEN;
  wire gs_ring = feed_reg == `ADCF_LF_RING_OPEN;
  wire gs = gs_tip || gs_ring;
  wire feed_open = feed_reg == `ADCF_LF_OPEN;
  wire [7:0] vdiff = (slow_reg.vtip >= slow_reg.vring) ?
                     slow_reg.vtip - slow_reg.vring :
                     slow_reg.vring - slow_reg.vtip;
  wire [7:0] vrep8 = gs ? slow_reg.vring : vdiff;
  wire [7:0] irep8 = gs ? slow_reg.iring : slow_reg.iloop;

  // Battery tracking
  wire [15:0] open_circuit_voltage_setting = cfg_reg[`ADCF_IDX_VOC];
  wire [16:0] ovh = {1'b0, cfg_reg[`ADCF_IDX_VOV]} +
                    {1'b0, cfg_reg[`ADCF_IDX_VCM]};
  wire [17:0] need = {2'b00, open_circuit_voltage_setting} + {1'b0, ovh};
  wire [16:0] vb17 = {1'b0, scale8(slow_reg.vbat)};
  wire [15:0] vb_less = (vb17 > ovh) ? 16'(vb17 - ovh) : 16'h0000;
  wire [15:0] track_next = ({1'b0, vb17} >= need) ? open_circuit_voltage_setting : vb_less;

  // Thresholds relative to tracked voltage
  wire signed [17:0] track_s = $signed({2'b00, track_next});
  wire signed [17:0] lth_s = 18'($signed(cfg_reg[`ADCF_IDX_LTH]));
  wire signed [17:0] hth_s = 18'($signed(cfg_reg[`ADCF_IDX_HTH]));
  wire signed [17:0] low_thr = track_s + lth_s;
  wire signed [17:0] high_thr = track_s + hth_s;
  wire signed [17:0] vloop_s = $signed({2'b00, scale8(vrep8)});
  wire go_post = vloop_s <= low_thr;
  wire go_pre = vloop_s >= high_thr;

  // Current limit
  wire [15:0] limit_ua = loop_current_limit_ua(cfg_reg[`ADCF_IDX_LOOP_CURRENT_LIMIT][4:0]);
  wire [16:0] iloop_ua = 17'(irep8 * CUR_LSB_UA);
  wire at_limit = iloop_ua >= {1'b0, limit_ua};

  // Boosted open-circuit voltage
  wire [16:0] boosted = {1'b0, track_reg} +
                        {1'b0, cfg_reg[`ADCF_IDX_BOOST]};
  wire [15:0] boost_sat = boosted[16] ? 16'hffff : boosted[15:0];
  // Zero boost leaves only the impedance step
  wire [15:0] ocv_now = (region_reg == ADCF_POST) ?
                        boost_sat : track_reg;

  // Detectors
  wire lc_flag;
  wire gk_flag;
  wire gk_rise = gk_flag && !gk_prev_reg;

  adcf_detect #(.W(16)) u_closure (
    .clk(clk),
    .nrst(nrst),
    .sample_en(eval_en_reg),
    .value(scale8(irep8)),
    .low_thr(cfg_reg[`ADCF_IDX_LC_ON]),
    .high_thr(cfg_reg[`ADCF_IDX_LC_OFF]),
    .filt_shift(cfg_reg[`ADCF_IDX_LC_FILT][3:0]),
    .debounce(cfg_reg[`ADCF_IDX_LC_DEB]),
    .flag(lc_flag)
  );

  adcf_detect #(.W(16)) u_ground_key (
    .clk(clk),
    .nrst(nrst),
    .sample_en(eval_en_reg),
    .value(scale8(slow_reg.ilong)),
    .low_thr(cfg_reg[`ADCF_IDX_GK_LO]),
    .high_thr(cfg_reg[`ADCF_IDX_GK_HI]),
    .filt_shift(cfg_reg[`ADCF_IDX_GK_FILT][3:0]),
    .debounce(cfg_reg[`ADCF_IDX_GK_DEB]),
    .flag(gk_flag)
  );

  // Feed state: hardware change wins over a write in the same cycle
  wire [2:0] gk_state = gs_tip ? `ADCF_LF_FWD : `ADCF_LF_REV;
  wire gk_move = gk_rise && gs;
  wire [2:0] feed_next = gk_move ? gk_state :
                         ctrl_wr ? avs_writedata[`ADCF_CTRL_FEED_MSB:0] :
                         feed_reg;

  // Calibration
  wire cal_start = ctrl_wr && avs_writedata[`ADCF_CTRL_CAL_BIT];
  wire cal_done = cal_cnt_reg == 16'(CAL_CYCLES - 1);

  // Outputs toward the linefeed driver
  adcf_feed_t feed_comb;
  assign feed_comb.state = feed_reg;
  assign feed_comb.tip_drive_en = !feed_open && !gs_tip;
  assign feed_comb.ring_drive_en = !feed_open && !gs_ring;
  assign feed_comb.imp_high = !disc_reg &&
                              (region_reg == ADCF_PRE);
  assign feed_comb.const_current = cc_reg;
  assign feed_comb.ocv = feed_open ? 16'h0000 : ocv_now;
  assign feed_comb.limit_ua = limit_ua;

  // Read mux
  wire [31:0] status_word = {27'h0, cal_reg == ADCF_CAL_RUN, cc_reg,
                             region_reg == ADCF_POST, gk_flag, lc_flag};
  wire [31:0] ctrl_word = {27'h0, cal_reg == ADCF_CAL_RUN, disc_reg,
                           feed_reg};
  wire [31:0] rd_mux =
    ctrl_hit ? ctrl_word :
    cfg_hit ? {16'h0000, cfg_reg[idx]} :
    (avs_address == `ADCF_OFS_STATUS) ? status_word :
    (avs_address == `ADCF_OFS_TRACK) ? {16'h0000, track_reg} :
    (avs_address == `ADCF_OFS_LOOP_V) ? {16'h0000, loop_v_reg} :
    (avs_address == `ADCF_OFS_LOOP_I) ? {16'h0000, loop_i_reg} :
    (avs_address == `ADCF_OFS_RING_V) ? {24'h0, vrng_reg} :
    (avs_address == `ADCF_OFS_RING_I) ? {24'h0, irng_reg} :
    32'h0000_0000;

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign feed_out = feed_out_reg;
  // Busy flag straight from the calibration state
  assign cal_active = cal_reg == ADCF_CAL_RUN;

  // Bus slave: one wait cycle, then answer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if (avs_read && wait_reg)
        rdata_reg <= rd_mux;
    end
  end

  // Settings words
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 1; i < 16; i++)
        cfg_reg[i] <= `ADCF_CFG_RST;
    end
    else if (wr_fire && cfg_hit)
      cfg_reg[idx] <= wmerge(cfg_reg[idx], avs_writedata, avs_byteenable);
  end

  // Control and ground key action
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      feed_reg <= `ADCF_LF_OPEN;
      disc_reg <= 1'b0;
      gk_prev_reg <= 1'b0;
    end
    else
    begin
      feed_reg <= feed_next;
      gk_prev_reg <= gk_flag;
      if (ctrl_wr)
        disc_reg <= avs_writedata[`ADCF_CTRL_DISC_BIT];
    end
  end

  // Calibration sequence
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_reg <= ADCF_CAL_IDLE;
      cal_cnt_reg <= 16'h0000;
    end
    else
    begin
      unique case (cal_reg)
        ADCF_CAL_IDLE:
        begin
          cal_cnt_reg <= 16'h0000;
          if (cal_start)
            cal_reg <= ADCF_CAL_RUN;
        end
        ADCF_CAL_RUN:
        begin
          cal_cnt_reg <= cal_cnt_reg + 16'h0001;
          if (cal_done)
            cal_reg <= ADCF_CAL_IDLE;
        end
      endcase
    end
  end

  // Sample rate dividers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slow_cnt_reg <= 16'h0000;
      fast_cnt_reg <= 16'h0000;
      slow_en_reg <= 1'b0;
      fast_en_reg <= 1'b0;
      eval_en_reg <= 1'b0;
    end
    else
    begin
      slow_cnt_reg <= slow_wrap ? 16'h0000 : slow_cnt_reg + 16'h0001;
      fast_cnt_reg <= fast_wrap ? 16'h0000 : fast_cnt_reg + 16'h0001;
      slow_en_reg <= slow_wrap;
      fast_en_reg <= fast_wrap;
      eval_en_reg <= slow_en_reg;
    end
  end

  // Sample capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slow_reg <= '0;
      vrng_reg <= `ADCF_SAMPLE_RST;
      irng_reg <= `ADCF_SAMPLE_RST;
    end
    else
    begin
      if (slow_en_reg)
        slow_reg <= slow_in;
      if (fast_en_reg)
      begin
        vrng_reg <= fast_in.vrng;
        irng_reg <= fast_in.irng;
      end
    end
  end

  // Adaptive region, evaluated once per sample
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      region_reg <= ADCF_PRE;
      cc_reg <= 1'b0;
      track_reg <= 16'h0000;
      loop_v_reg <= 16'h0000;
      loop_i_reg <= 16'h0000;
    end
    else if (eval_en_reg)
    begin
      track_reg <= track_next;
      loop_v_reg <= scale8(vrep8);
      loop_i_reg <= scale8(irep8);
      if (feed_open)
        region_reg <= ADCF_PRE;
      else if (region_reg == ADCF_PRE && go_post)
        region_reg <= ADCF_POST;
      else if (region_reg == ADCF_POST && go_pre)
        region_reg <= ADCF_PRE;
      cc_reg <= !feed_open && region_reg == ADCF_POST &&
                !go_pre && at_limit;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      feed_out_reg <= '0;
    else
      feed_out_reg <= feed_comb;
  end
endmodule : adcf_ctrl

/* adcf_ctrl_chk.sv */
/*
  Port checker of the adaptive dc feed controller, bound to adcf_ctrl.
  Assumes the bind hands on the design's CAL_CYCLES value.
*/
`timescale 1ns/1ps
module adcf_ctrl_chk #(
  parameter int CAL_CYCLES = 1024
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire adcf_pkg::adcf_feed_t feed_out,
  input wire logic cal_active
);
  import adcf_pkg::*;
  logic [15:0] cal_cnt_reg;
  wire logic [15:0] cal_cnt_next = cal_active ? cal_cnt_reg + 16'h0001 :
                                   16'h0000;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      cal_cnt_reg <= 16'h0000;
    else
      cal_cnt_reg <= cal_cnt_next;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_req_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait state");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_open_quiet: assert property (feed_out.state == 3'h0 |->
    !feed_out.tip_drive_en && !feed_out.ring_drive_en && feed_out.ocv == 16'h0)
    else $error("open state drives the line");
  a_tip_float: assert property (feed_out.state == 3'h3 |->
    !feed_out.tip_drive_en && feed_out.ring_drive_en) else $error("tip float");
  a_ring_float: assert property (feed_out.state == 3'h7 |->
    feed_out.tip_drive_en && !feed_out.ring_drive_en)
    else $error("ring float");
  a_limit_steps: assert property (feed_out.state != 3'h0 |->
    int'(feed_out.limit_ua) >= 18000 && int'(feed_out.limit_ua) <= 45125
    && (int'(feed_out.limit_ua) - 18000) % 875 == 0) else $error("bad limit");
  a_const_low_imp: assert property (feed_out.const_current |->
    !feed_out.imp_high) else $error("constant current in high impedance");
  a_cal_bounded: assert property (int'(cal_cnt_reg) <= CAL_CYCLES)
    else $error("calibration does not end");
  a_cal_min_run: assert property ($rose(cal_active) |->
    cal_active [*4]) else $error("calibration too short");
  cover property ($fell(feed_out.imp_high));
  cover property (feed_out.const_current);
  cover property (feed_out.state == 3'h3 ##1 feed_out.state == 3'h1);
  cover property ($fell(cal_active));
endmodule : adcf_ctrl_chk
bind adcf_ctrl adcf_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_i (.clk(clk),
  .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .feed_out(feed_out),
  .cal_active(cal_active));

/* adcf_loop_model.sv */
/*
  Subscriber loop seen through the linefeed driver.
  Assumes the bench sets load voltage, currents and battery.
*/
`timescale 1ns/1ps
module adcf_loop_model (
  input wire logic clk,
  input wire adcf_pkg::adcf_feed_t feed,
  input wire logic [7:0] load_v,
  input wire logic [7:0] load_i,
  input wire logic [7:0] long_i,
  input wire logic [7:0] batt,
  output adcf_pkg::adcf_slow_t slow
);
  import adcf_pkg::*;
  logic flip_reg = 1'b0;
  wire logic both = feed.tip_drive_en && feed.ring_drive_en;
  always_ff @(posedge clk)
    flip_reg <= ~flip_reg;
  // Released lead shows a toggling pattern
  assign slow.vtip = feed.tip_drive_en ? load_v : {8{flip_reg}};
  assign slow.vring = !feed.ring_drive_en ? {8{~flip_reg}}
    : both ? 8'h00 : load_v;
  assign slow.iloop = both ? load_i : 8'h00;
  assign slow.iring = feed.ring_drive_en ? load_i : 8'h00;
  assign slow.ilong = long_i;
  assign slow.vbat = batt;
endmodule : adcf_loop_model

/* adcf_ctrl_tb.sv */
/*
  Self-checking bench of the adaptive dc feed controller.
  Assumes adcf_map.svh, the package, loop model and checker.
*/
`timescale 1ns/1ps
`include "adcf_map.svh"
module adcf_ctrl_tb;
  import adcf_pkg::*;
  localparam int SLOW = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  adcf_slow_t slow_in;
  adcf_fast_t fast_in = '0;
  adcf_feed_t feed_out;
  logic cal_active;
  logic [7:0] load_v = 8'h30;
  logic [7:0] load_i = 8'h00;
  logic [7:0] long_i = 8'h00;
  logic [7:0] batt = 8'hff;
  logic [31:0] q;
  logic [31:0] rnd = 32'd58;
  int err_count = 0;
  int checks_done = 0;
  int open_circuit_voltage_setting, overhead_voltage, common_mode_voltage, bst, lim;
  always #50 clk = ~clk;
  adcf_ctrl #(.SLOW_DIV(SLOW), .FAST_DIV(5), .CAL_CYCLES(8)) uut (.clk(clk),
    .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slow_in(slow_in),
    .fast_in(fast_in), .feed_out(feed_out), .cal_active(cal_active));
  adcf_loop_model loop_i (.clk(clk), .feed(feed_out), .load_v(load_v),
    .load_i(load_i), .long_i(long_i), .batt(batt), .slow(slow_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int enc(input int mv);
    return 2 * (((mv + 502) / 1005 * 512 + 4) / 5);
  endfunction : enc
  function automatic int track(input int b);
    return b * 256 >= open_circuit_voltage_setting + overhead_voltage + common_mode_voltage ? open_circuit_voltage_setting : b * 256 - overhead_voltage - common_mode_voltage;
  endfunction : track
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
      n++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(n, 1);
    @(posedge clk);
  endtask : bus
  task automatic wset(input logic [3:0] idx, input int v);
    bus(1'b1, {2'b00, idx, 2'b00}, v);
  endtask : wset
  task automatic stim(input logic [7:0] v, input logic [7:0] i,
    input logic [7:0] g);
    rnd = xs(rnd);
    load_v <= v;
    load_i <= i;
    long_i <= g;
    fast_in <= rnd[15:0];
    repeat (3 * SLOW) @(posedge clk);
  endtask : stim
  initial
  begin
    repeat (10000) @(posedge clk);
    chk(1, 0);
    stop_test();
  end
  initial
  begin
    logic [2:0] s;
    open_circuit_voltage_setting = enc(48000);
    overhead_voltage = enc(4000);
    common_mode_voltage = enc(3000);
    bst = enc(6000);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(feed_out, 40'h0);
    chk(cal_active, 0);
    bus(1'b0, `ADCF_OFS_STATUS, 0);
    chk(q, 0);
    wset(4'h0, 32'h10);
    chk(cal_active, 1);
    repeat (12) @(posedge clk);
    bus(1'b0, `ADCF_OFS_CTRL, 0);
    chk(q, 0);
    wset(`ADCF_IDX_VOC, open_circuit_voltage_setting);
    wset(`ADCF_IDX_VOV, overhead_voltage);
    wset(`ADCF_IDX_VCM, common_mode_voltage);
    wset(`ADCF_IDX_LTH, -enc(7000));
    wset(`ADCF_IDX_HTH, enc(2000));
    wset(`ADCF_IDX_BOOST, bst);
    wset(`ADCF_IDX_LC_OFF, 32'h2000);
    wset(`ADCF_IDX_LC_ON, 32'h1000);
    wset(`ADCF_IDX_GK_LO, 32'h1000);
    wset(`ADCF_IDX_GK_HI, 32'h8000);
    rnd = xs(rnd);
    lim = 18000 + 875 * rnd[4:0];
    wset(`ADCF_IDX_LOOP_CURRENT_LIMIT, rnd[4:0]);
    wset(4'h0, 32'h1);
    stim(8'h30, 8'h00, 8'h00);
    chk(feed_out.limit_ua, lim);
    chk(feed_out.imp_high, 1);
    chk(feed_out.ocv, open_circuit_voltage_setting);
    bus(1'b0, `ADCF_OFS_RING_V, 0);
    chk(q, fast_in.vrng);
    bus(1'b0, `ADCF_OFS_RING_I, 0);
    chk(q, fast_in.irng);
    repeat (4)
    begin
      rnd = xs(rnd);
      batt <= rnd[7:0] | 8'h20;
      stim(8'h30, 8'h00, 8'h00);
      bus(1'b0, `ADCF_OFS_TRACK, 0);
      chk(q, track(batt));
    end
    batt <= 8'hff;
    stim(8'h20, 8'h00, 8'h00);
    chk(feed_out.imp_high, 0);
    chk(feed_out.ocv, open_circuit_voltage_setting + bst);
    stim(8'h20, (lim + 399) / 400 - 1, 8'h00);
    chk(feed_out.const_current, 0);
    stim(8'h20, (lim + 399) / 400, 8'h00);
    chk(feed_out.const_current, 1);
    bus(1'b0, `ADCF_OFS_LOOP_I, 0);
    chk(q, (lim + 399) / 400 * 256);
    stim(8'h28, 8'h00, 8'h00);
    chk(feed_out.imp_high, 0);
    stim(8'h29, 8'h00, 8'h00);
    chk(feed_out.imp_high, 1);
    chk(feed_out.ocv, open_circuit_voltage_setting);
    stim(8'h30, 8'h40, 8'h00);
    bus(1'b0, `ADCF_OFS_STATUS, 0);
    chk(q[0], 1);
    stim(8'h30, 8'h00, 8'h00);
    bus(1'b0, `ADCF_OFS_STATUS, 0);
    chk(q[0], 0);
    wset(`ADCF_IDX_BOOST, 0);
    stim(8'h20, 8'h00, 8'h00);
    chk({feed_out.imp_high, feed_out.ocv}, open_circuit_voltage_setting);
    wset(4'h0, 32'h9);
    stim(8'h30, 8'h00, 8'h00);
    chk(feed_out.imp_high, 0);
    for (int k = 0; k < 2; k++)
    begin
      s = k ? 3'h7 : 3'h3;
      wset(4'h0, s);
      stim(8'h30, 8'h00, 8'h00);
      chk({feed_out.tip_drive_en, feed_out.ring_drive_en}, k + 1);
      bus(1'b0, `ADCF_OFS_LOOP_V, 0);
      if (k == 0)
        chk(q, 32'h3000);
      stim(8'h20, 8'h00, 8'h00);
      if (k == 0)
        chk(feed_out.imp_high, 0);
      stim(8'h30, 8'h00, 8'hff);
      chk(feed_out.state, k ? 5 : 1);
      bus(1'b0, `ADCF_OFS_STATUS, 0);
      chk(q[1], 1);
      stim(8'h30, 8'h00, 8'h00);
    end
    bus(1'b0, 8'h80, 0);
    chk(q, 0);
    bus(1'b1, `ADCF_OFS_TRACK, 0);
    bus(1'b0, `ADCF_OFS_TRACK, 0);
    chk(q, open_circuit_voltage_setting);
    stop_test();
  end
endmodule : adcf_ctrl_tb
